// [include/tpm_pkg.sv]
// Purpose: Shared constants and types for the port mask and control register bank
// Assumes: Byte-wide register port, index-addressed as printed
// Notes: Power event mask offset is a local choice

package tpm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_POWER_EVENT_MASK = 8'h14;
  localparam logic [7:0] OFF_FAULT_EVENT_MASK = 8'h15;
  localparam logic [7:0] OFF_STD_OUT_CONFIG = 8'h18;
  localparam logic [7:0] OFF_PORT_CONTROL = 8'h19;

  // Reset values
  localparam logic [7:0] RST_POWER_EVENT_MASK = 8'hff;
  localparam logic [7:0] RST_FAULT_EVENT_MASK = 8'h7f;
  localparam logic [7:0] RST_STD_OUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_PORT_CONTROL = 8'h00;

  // Power event mask bit positions
  localparam int unsigned PB_INIT = 6;
  localparam int unsigned PB_BUS_DET = 3;
  localparam int unsigned PB_BUS_PRES = 2;
  localparam int unsigned PB_CABLE_PRES = 1;

  // Fault event mask bit positions
  localparam int unsigned FB_CABLE_OV = 7;
  localparam int unsigned FB_FORCED_OFF = 6;
  localparam int unsigned FB_AUTO_DISC = 5;
  localparam int unsigned FB_FORCED_DISC = 4;
  localparam int unsigned FB_CABLE_OC = 1;
  localparam int unsigned FB_LINK_ERR = 0;

  // Port control fields
  localparam int unsigned CB_FLIP = 0;
  localparam int unsigned CB_TEST = 1;
  localparam logic [7:0] PORT_CONTROL_WMASK = 8'h03;

  // Power events that can be gated (positions match the mask register)
  localparam logic [7:0] POWER_GATED_BITS = 8'h4e;
  // Fault events that can be gated; bits 3 and 2 have no effect
  localparam logic [7:0] FAULT_GATED_BITS = 8'hf3;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tpm_req_t;

  // Routing of the configuration channel pins
  typedef struct packed {
    logic cc1_vconn;
    logic cc2_vconn;
    logic cc1_rx;
    logic cc2_rx;
  } tpm_route_t;

  typedef enum logic [1:0] {
    TPM_NORMAL = 2'b01,
    TPM_TEST = 2'b10
  } tpm_mode_t;

endpackage

// [src/tpm_route.sv]
// Purpose: Steers cable power and message receive to opposite configuration pins
// Assumes: Inputs synchronous to clk
// Notes: Registered outputs

`timescale 1ns/1ps

module tpm_route
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flip,
  input wire logic cable_power_source_on,
  input wire logic pd_rx_enable,
  output tpm_route_t route_q
);

  tpm_route_t route_d;

  // Orientation picks the pins
  always_comb
  begin
    route_d = '0;
    route_d.cc2_vconn = cable_power_source_on && !flip;
    route_d.cc1_rx = pd_rx_enable && !flip;
    route_d.cc1_vconn = cable_power_source_on && flip;
    route_d.cc2_rx = pd_rx_enable && flip;
  end

  // Register the routing
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      route_q <= '0;
    else
      route_q <= route_d;
  end

endmodule // tpm_route

// [src/tpm_regs.sv]
// Purpose: Mask and port control registers of a Type-C port controller
// Assumes: Host transactions arrive as one-cycle read or write strobes
// Notes: Alert flags clear on the flags_read strobe; no register in this bank clears them

`timescale 1ns/1ps

module tpm_regs
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input tpm_req_t req,
  output logic [DATA_W-1:0] rdata_q,
  output logic rvalid_q,
  input wire logic [7:0] power_events,
  input wire logic [7:0] fault_events,
  input wire logic flags_read,
  output logic power_change_flag_q,
  output logic fault_flag_q,
  output logic alert_q,
  input wire logic rx_message,
  output logic rx_report_q,
  output logic rx_ack_q,
  input wire logic cable_power_source_on,
  input wire logic pd_rx_enable,
  output tpm_route_t route_q,
  output logic [7:0] power_event_mask_q,
  output logic [7:0] fault_event_mask_q,
  output logic compliance_test_select_q,
  output logic cable_flip_select_q
);

  logic [7:0] power_mask_d;
  logic [7:0] fault_mask_d;
  logic [7:0] std_cfg_q;
  logic [7:0] std_cfg_d;
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_d;
  logic power_flag_d;
  logic fault_flag_d;
  logic alert_d;
  logic rx_report_d;
  logic rx_ack_d;
  logic power_fire;
  logic fault_fire;
  tpm_mode_t mode;

  // Write hit on one register
  function automatic logic hit(input tpm_req_t r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction

  // Register writes
  always_comb
  begin
    power_mask_d = power_event_mask_q;
    fault_mask_d = fault_event_mask_q;
    std_cfg_d = std_cfg_q;
    ctl_d = ctl_q;
    if (hit(req, OFF_POWER_EVENT_MASK))
      power_mask_d = req.wdata;
    if (hit(req, OFF_FAULT_EVENT_MASK))
      fault_mask_d = req.wdata;
    if (hit(req, OFF_STD_OUT_CONFIG))
      std_cfg_d = req.wdata;
    if (hit(req, OFF_PORT_CONTROL))
      ctl_d = req.wdata & PORT_CONTROL_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      power_event_mask_q <= RST_POWER_EVENT_MASK;
      fault_event_mask_q <= RST_FAULT_EVENT_MASK;
      std_cfg_q <= RST_STD_OUT_CONFIG;
      ctl_q <= RST_PORT_CONTROL;
    end
    else
    begin
      power_event_mask_q <= power_mask_d;
      fault_event_mask_q <= fault_mask_d;
      std_cfg_q <= std_cfg_d;
      ctl_q <= ctl_d;
    end
  end

  assign compliance_test_select_q = ctl_q[CB_TEST];
  assign cable_flip_select_q = ctl_q[CB_FLIP];
  assign mode = ctl_q[CB_TEST] ? TPM_TEST : TPM_NORMAL;

  // Read path: one-cycle answer, unmapped reads zero
  always_comb
  begin
    rvalid_d = req.rd;
    rdata_d = '0;
    if (req.rd)
    begin
      unique case (req.addr)
        OFF_POWER_EVENT_MASK: rdata_d = power_event_mask_q;
        OFF_FAULT_EVENT_MASK: rdata_d = fault_event_mask_q;
        OFF_STD_OUT_CONFIG: rdata_d = std_cfg_q;
        OFF_PORT_CONTROL: rdata_d = ctl_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Gate events by the supported mask bits only
  assign power_fire = |(power_events & power_event_mask_q & POWER_GATED_BITS);
  assign fault_fire = |(fault_events & fault_event_mask_q & FAULT_GATED_BITS);

  // Sticky flags: a new event beats the read clear
  always_comb
  begin
    power_flag_d = power_change_flag_q;
    fault_flag_d = fault_flag_q;
    if (flags_read)
    begin
      power_flag_d = 1'b0;
      fault_flag_d = 1'b0;
    end
    if (power_fire)
      power_flag_d = 1'b1;
    if (fault_fire)
      fault_flag_d = 1'b1;
    alert_d = power_flag_d || fault_flag_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      power_change_flag_q <= 1'b0;
      fault_flag_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      power_change_flag_q <= power_flag_d;
      fault_flag_q <= fault_flag_d;
      alert_q <= alert_d;
    end
  end

  // Incoming message handling by mode
  always_comb
  begin
    rx_report_d = 1'b0;
    rx_ack_d = 1'b0;
    unique case (mode)
      TPM_NORMAL: rx_report_d = rx_message;
      TPM_TEST: rx_ack_d = rx_message;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_report_q <= 1'b0;
      rx_ack_q <= 1'b0;
    end
    else
    begin
      rx_report_q <= rx_report_d;
      rx_ack_q <= rx_ack_d;
    end
  end

  // Pin routing from orientation
  tpm_route u_route (
    .clk(clk),
    .rst_b(rst_b),
    .flip(ctl_q[CB_FLIP]),
    .cable_power_source_on(cable_power_source_on),
    .pd_rx_enable(pd_rx_enable),
    .route_q(route_q)
  );

endmodule // tpm_regs

// [verif/tpm_regs_properties.sv]
// Purpose: Port-level checks for tpm_regs
// Assumes: One clock, synchronous reset
// Notes: Bound to tpm_regs below
`timescale 1ns/1ps
module tpm_regs_properties
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input tpm_req_t req,
  input wire logic rvalid_q,
  input wire logic [7:0] power_events,
  input wire logic [7:0] fault_events,
  input wire logic flags_read,
  input wire logic power_change_flag_q,
  input wire logic fault_flag_q,
  input wire logic alert_q,
  input wire logic rx_message,
  input wire logic rx_report_q,
  input wire logic rx_ack_q,
  input wire logic cable_power_source_on,
  input wire logic pd_rx_enable,
  input tpm_route_t route_q,
  input wire logic [7:0] power_event_mask_q,
  input wire logic [7:0] fault_event_mask_q,
  input wire logic compliance_test_select_q,
  input wire logic cable_flip_select_q
);
  logic [7:0] pg;
  logic [7:0] fg;
  logic [3:0] rt;
  logic f;
  // Unmasked events and the routing expected from this cycle's inputs
  assign pg = power_events & power_event_mask_q & 8'h4e;
  assign fg = fault_events & fault_event_mask_q & 8'hf3;
  assign f = cable_flip_select_q;
  assign rt = {f & cable_power_source_on, !f & cable_power_source_on,
    !f & pd_rx_enable, f & pd_rx_enable};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (req.rd |=> rvalid_q) else $error("no read answer");
  a_power_set: assert property (|pg |=> power_change_flag_q && alert_q) else $error("pw");
  a_power_cause: assert property ($rose(power_change_flag_q) |-> $past(|pg)) else $error("pc");
  a_fault_set: assert property (|fg |=> fault_flag_q && alert_q) else $error("fs");
  a_fault_cause: assert property ($rose(fault_flag_q) |-> $past(|fg)) else $error("fc");
  a_alert_or: assert property (alert_q == (power_change_flag_q || fault_flag_q)) else $error("al");
  a_flag_clear: assert property (flags_read && !(|pg) |=> !power_change_flag_q) else $error("cl");
  a_rx_normal: assert property (rx_message && !compliance_test_select_q |=> rx_report_q && !rx_ack_q)
    else $error("rn");
  a_rx_test: assert property (rx_message && compliance_test_select_q |=> rx_ack_q && !rx_report_q)
    else $error("rt");
  a_pin_route: assert property ($past(rst_b) |-> route_q == $past(rt)) else $error("ro");
  c_power_flag: cover property (|pg ##1 power_change_flag_q);
  c_test_ack: cover property (rx_ack_q);
  c_flip_route: cover property (route_q.cc1_vconn);
endmodule // tpm_regs_properties
bind tpm_regs tpm_regs_properties u_tpm_regs_properties (.*);

// [verif/tpm_host.sv]
// Purpose: Host model issuing register accesses
// Assumes: Called just after a clock edge
// Notes: Idle bus shows inverted last values
`timescale 1ns/1ps
module tpm_host
  import tpm_pkg::*;
(
  input wire logic clk,
  output tpm_req_t req,
  input wire logic rvalid_q,
  input wire logic [7:0] rdata_q
);
  // Idle bus at start
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 req = {2'b10, a, v};
    @(posedge clk);
    #1 req = {2'b00, ~a, ~v};
  endtask
  // Read answer is taken in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 req = {2'b01, a, 8'h00};
    @(posedge clk);
    #1 req = {2'b00, ~a, 8'hff};
    v = rvalid_q ? rdata_q : 8'hxx;
  endtask
endmodule // tpm_host

// [verif/test_typec_port_mask_and_control_regs.sv]
// Purpose: Self-checking bench for tpm_regs
// Assumes: Inputs change 1 ns after clk rises
// Notes: Register traffic goes through tpm_host
`timescale 1ns/1ps
module test_typec_port_mask_and_control_regs
  import tpm_pkg::*;
;
  logic clk, rst_b, flags_read, rx_message, cable_power_source_on, pd_rx_enable;
  logic rvalid_q, power_change_flag_q, fault_flag_q, alert_q, rx_report_q, rx_ack_q;
  logic compliance_test_select_q, cable_flip_select_q;
  logic [7:0] rdata_q, power_events, fault_events, power_event_mask_q, fault_event_mask_q;
  logic [7:0] d;
  tpm_req_t req;
  tpm_route_t route_q;
  int err_count, n_compared;
  tpm_regs u_tpm_regs (.*);
  tpm_host u_tpm_host (.*);
  // Clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %0t: got %h exp %h", $time, g, e);
      err_count++;
    end
  endtask
  task t_reset;
    logic [7:0] a [5] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h16};
    logic [7:0] e [5] = '{8'hff, 8'h7f, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      u_tpm_host.rd(a[i], d);
      chk(d, e[i]);
    end
  endtask
  task t_write;
    u_tpm_host.wr(OFF_PORT_CONTROL, 8'hfc);
    u_tpm_host.rd(OFF_PORT_CONTROL, d);
    chk(d, 8'h00);
    u_tpm_host.wr(OFF_STD_OUT_CONFIG, 8'h5a);
    u_tpm_host.rd(OFF_STD_OUT_CONFIG, d);
    chk(d, 8'h5a);
  endtask
  task t_gate;
    logic [7:0] m, g;
    for (int f = 0; f < 2; f++)
      for (int i = 0; i < 8; i++)
        for (int k = 0; k < 2; k++)
        begin
          m = 8'h01 << i;
          g = f ? 8'hf3 : 8'h4e;
          u_tpm_host.wr(f ? OFF_FAULT_EVENT_MASK : OFF_POWER_EVENT_MASK, k ? ~m : m);
          @(posedge clk);
          #1 {fault_events, power_events} = f ? {m, 8'h00} : {8'h00, m};
          @(posedge clk);
          #1 {fault_events, power_events} = 16'h0000;
          chk({5'h00, alert_q, fault_flag_q, power_change_flag_q},
            k ? 8'h00 : {5'h00, g[i], g[i] & (f == 1), g[i] & (f == 0)});
          @(posedge clk);
          #1 flags_read = 1;
          @(posedge clk);
          #1 flags_read = 0;
          chk({7'h00, alert_q}, 8'h00);
        end
  endtask
  task t_rx;
    for (int t = 0; t < 2; t++)
    begin
      u_tpm_host.wr(OFF_PORT_CONTROL, t ? 8'h02 : 8'h00);
      @(posedge clk);
      #1 rx_message = 1;
      @(posedge clk);
      #1 rx_message = 0;
      chk({6'h00, rx_ack_q, rx_report_q}, t ? 8'h02 : 8'h01);
    end
    u_tpm_host.wr(OFF_PORT_CONTROL, 8'h00);
  endtask
  task t_route;
    for (int c = 0; c < 8; c++)
    begin
      u_tpm_host.wr(OFF_PORT_CONTROL, {7'h00, c[0]});
      cable_power_source_on = c[1];
      pd_rx_enable = c[2];
      repeat (2) @(posedge clk);
      #1 chk({4'h0, route_q}, {4'h0, c[0] & c[1], !c[0] & c[1], !c[0] & c[2], c[0] & c[2]});
    end
  endtask
  task test_done;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done;
  end
  // Main sequence
  initial
  begin
    {flags_read, rx_message, cable_power_source_on, pd_rx_enable} = 4'h0;
    {power_events, fault_events} = 16'h0000;
    err_count = 0;
    n_compared = 0;
    rst_b = 0;
    repeat (12) @(posedge clk);
    #1 rst_b = 1;
    t_reset;
    t_write;
    t_gate;
    t_rx;
    t_route;
    test_done;
  end
endmodule // test_typec_port_mask_and_control_regs
